// [design/rsc_pkg.sv]
// Constants, state codes and carriers shared by the reset source controller
`default_nettype none
package rsc_pkg;

  // ---------------------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------------------
  localparam logic [15:0] CAUSE_ADDR      = 16'hFF54;
  localparam int          WDT_FLAG_BIT    = 4;
  localparam int          LV_FLAG_BIT     = 0;
  localparam logic [7:0]  CAUSE_RST       = 8'h00;

  // ---------------------------------------------------------------------------
  // Reset vector and values forced at reset acknowledgment
  // ---------------------------------------------------------------------------
  localparam logic [15:0] VEC_ADDR_LO     = 16'h0000;
  localparam logic [15:0] VEC_ADDR_HI     = 16'h0001;
  localparam logic [7:0]  PSW_RST         = 8'h02;
  localparam logic [15:0] TMR16_RST       = 16'h0000;
  localparam logic [7:0]  SER_MODE_RST    = 8'h01;
  localparam logic [7:0]  SER_CTL_RST     = 8'h16;
  localparam logic [7:0]  MASK_RST        = 8'hFF;
  localparam logic [7:0]  LV_REG_RST      = 8'h00;

  // ---------------------------------------------------------------------------
  // Option byte fields and timing
  // ---------------------------------------------------------------------------
  localparam int          OPT_XTAL_BIT    = 0;
  localparam int          OPT_PIN_IN_BIT  = 1;
  localparam int          STAB_CYCLES     = 16384;
  localparam logic [15:0] CNT_RST         = 16'h0000;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    RSC_HOLD,
    RSC_OPTION,
    RSC_STAB,
    RSC_VEC_LO,
    RSC_VEC_HI,
    RSC_RUN
  } rsc_state_t;

  // Sources that arrive from outside the clock domain
  typedef struct packed {
    logic pin_low;
    logic poc_low;
    logic lvd_low;
  } rsc_async_t;

  typedef struct packed {
    logic [7:0]  processor_status_word;
    logic [15:0] timer16_counter;
    logic [15:0] timer16_capture_a;
    logic [15:0] timer16_capture_b;
    logic [7:0]  serial_operation_mode;
    logic [7:0]  serial_control;
    logic [7:0]  interrupt_mask_low;
    logic [7:0]  interrupt_mask_high;
    logic [7:0]  low_voltage_control;
    logic [7:0]  low_voltage_level_select;
  } rsc_defaults_t;

  localparam rsc_defaults_t RSC_DEFAULTS = '{
    processor_status_word:    PSW_RST,
    timer16_counter:          TMR16_RST,
    timer16_capture_a:        TMR16_RST,
    timer16_capture_b:        TMR16_RST,
    serial_operation_mode:    SER_MODE_RST,
    serial_control:           SER_CTL_RST,
    interrupt_mask_low:       MASK_RST,
    interrupt_mask_high:      MASK_RST,
    low_voltage_control:      LV_REG_RST,
    low_voltage_level_select: LV_REG_RST
  };

endpackage : rsc_pkg
`default_nettype wire

// [design/rsc_sync2.sv]
// Two-stage synchronizer for the pin and comparator levels
`default_nettype none
module rsc_sync2 (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          srst,
  // Levels
  input  wire rsc_pkg::rsc_async_t d,
  output rsc_pkg::rsc_async_t      q
);

  typedef struct packed {
    rsc_pkg::rsc_async_t meta;
    rsc_pkg::rsc_async_t stable;
  } rsc_sync_st_t;

  rsc_sync_st_t st_reg;
  rsc_sync_st_t st_next;

  // First stage feeds only the second
  always_comb begin
    st_next.meta   = d;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.stable;

endmodule : rsc_sync2
`default_nettype wire

// [design/rsc_reset_bridge.sv]
// Reset bridge: asynchronous assertion, two-edge synchronous release
`default_nettype none
module rsc_reset_bridge (
  // Clock
  input  wire logic clk_sys,
  // Raw request, any level source
  input  wire logic arst_req,
  // Conditioned reset
  output logic      rst_out
);

  logic [1:0] st_reg;
  logic [1:0] st_next;

  always_comb begin
    st_next = {st_reg[0], 1'h0};
  end

  // Release lands on a clock edge so the sequencer never sees a runt
  always_ff @(posedge clk_sys or posedge arst_req) begin
    if (arst_req) begin
      st_reg <= 2'h3;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rst_out = st_reg[1];

endmodule : rsc_reset_bridge
`default_nettype wire

// [design/rsc_controller.sv]
// Reset source controller: source merge, release sequence, cause flags
//
// Summary of operation
// - All four sources act alike; vector is then fetched from 0000H and 0001H.
// - During reset and stabilization ports float, one dedicated bit drives low.
// - Pin release: read option byte, optional stabilization wait, then run.
// - Watchdog reset releases itself and runs the same release sequence.
// - Comparator resets hold while supply is low, then release normally.
// - Reset pin low stops the system and low-speed oscillators.
// - Pin in input mode still resets until the release sequence reaches run.
// - Low-voltage reset does not reset the low-voltage detector itself.
// - Watchdog reset also resets the watchdog.
// - Only the program counter is undefined until reset acknowledgment.
// - Acknowledgment loads status word 02H; stack and RAM untouched.
// - Acknowledgment clears timer counter and both capture registers.
// - Acknowledgment sets serial mode 01H and serial control 16H.
// - Acknowledgment sets both interrupt mask registers to FFH.
// - Low-voltage registers cleared by pin, power-on, watchdog; kept otherwise.
// - Cause register read-only at FF54H: bit 4 watchdog, bit 0 low voltage.
// - Pin reset, power-on reset and a read of FF54H clear the cause register.
// - Watchdog or low-voltage reset sets its own flag, keeps the other.
`default_nettype none
module rsc_controller #(
  parameter int STAB_CYCLES = rsc_pkg::STAB_CYCLES
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          srst,
  // Reset sources
  input  wire logic          reset_pin_n,
  input  wire logic          watchdog_overflow,
  input  wire logic          power_on_clear_low,
  input  wire logic          low_voltage_detector_low,
  // Option byte fetch
  output logic               option_fetch_req,
  input  wire logic          option_valid,
  input  wire logic [7:0]    option_data,
  // CPU side
  output logic               internal_reset,
  output logic               cpu_reset,
  output logic               pc_undefined,
  output logic               vector_fetch,
  output logic [15:0]        vector_addr,
  output logic               defaults_load,
  output rsc_pkg::rsc_defaults_t defaults,
  // Pins and oscillators
  output logic               port_hiz,
  output logic               low_driven_port_bit_out,
  output logic               low_driven_port_bit_oe,
  output logic               osc_stop_sys,
  output logic               osc_stop_lowspeed,
  // Resets to other units
  output logic               watchdog_unit_reset,
  output logic               low_voltage_detector_reset,
  output logic               low_voltage_regs_clear,
  // Cause register read port
  input  wire logic          rd_en,
  input  wire logic [15:0]   rd_addr,
  output logic [7:0]         rd_data
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    rsc_pkg::rsc_state_t    state;
    logic [15:0]            cnt;
    logic                   watchdog_cause_flag;
    logic                   low_voltage_cause_flag;
    logic                   reset_pin_as_input;
    logic                   xtal;
    logic [7:0]             rd_data;
    logic                   opt_req;
    logic                   cpu_reset;
    logic                   pc_undef;
    logic                   vec_fetch;
    logic [15:0]            vec_addr;
    logic                   dflt_load;
    rsc_pkg::rsc_defaults_t dflt;
    logic                   port_hiz;
    logic                   osc_stop;
    logic                   wdt_rst;
    logic                   lvd_rst;
    logic                   lv_clr;
  } rsc_ctl_st_t;

  localparam rsc_ctl_st_t ST_RST = '{
    state:                  rsc_pkg::RSC_HOLD,
    cnt:                    rsc_pkg::CNT_RST,
    watchdog_cause_flag:    1'h0,
    low_voltage_cause_flag: 1'h0,
    reset_pin_as_input:     1'h0,
    xtal:                   1'h0,
    rd_data:                rsc_pkg::CAUSE_RST,
    opt_req:                1'h0,
    cpu_reset:              1'h1,
    pc_undef:               1'h1,
    vec_fetch:              1'h0,
    vec_addr:               rsc_pkg::VEC_ADDR_LO,
    dflt_load:              1'h0,
    dflt:                   rsc_pkg::RSC_DEFAULTS,
    port_hiz:               1'h1,
    osc_stop:               1'h0,
    wdt_rst:                1'h0,
    lvd_rst:                1'h0,
    lv_clr:                 1'h0
  };

  localparam logic [15:0] STAB_LAST = 16'(STAB_CYCLES - 1);

  rsc_ctl_st_t         st_reg;
  rsc_ctl_st_t         st_next;
  rsc_pkg::rsc_async_t raw_src;
  rsc_pkg::rsc_async_t sync_src;
  logic                pin_reset_en;
  logic                arst_req;
  logic                int_rst;
  logic                pin_src;
  logic                cause_hit;

  // ---------------------------------------------------------------------------
  // Source merge
  // ---------------------------------------------------------------------------
  // Pin counts as reset unless input mode was confirmed by the last option read and the sequence is in run
  assign pin_reset_en = !st_reg.reset_pin_as_input || (st_reg.state != rsc_pkg::RSC_RUN);

  // Gating term is decoded from flops only, so the async request only glitches with its sources
  assign arst_req = (!reset_pin_n && pin_reset_en) || watchdog_overflow
                  || power_on_clear_low || low_voltage_detector_low;

  assign raw_src.pin_low = !reset_pin_n;
  assign raw_src.poc_low = power_on_clear_low;
  assign raw_src.lvd_low = low_voltage_detector_low;

  rsc_sync2 u_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .d       (raw_src),
    .q       (sync_src)
  );

  rsc_reset_bridge u_bridge (
    .clk_sys  (clk_sys),
    .arst_req (arst_req),
    .rst_out  (int_rst)
  );

  assign pin_src   = sync_src.pin_low && pin_reset_en;
  assign cause_hit = rd_en && (rd_addr == rsc_pkg::CAUSE_ADDR);

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    st_next           = st_reg;
    st_next.vec_fetch = 1'h0;
    st_next.dflt_load = 1'h0;
    st_next.dflt      = rsc_pkg::RSC_DEFAULTS;

    // Cause register: read first, then hardware clears, sets last so a set wins
    if (rd_en) begin
      st_next.rd_data = 8'h00;
    end
    if (cause_hit) begin
      st_next.rd_data[rsc_pkg::WDT_FLAG_BIT] = st_reg.watchdog_cause_flag;
      st_next.rd_data[rsc_pkg::LV_FLAG_BIT]  = st_reg.low_voltage_cause_flag;
      st_next.watchdog_cause_flag            = 1'h0;
      st_next.low_voltage_cause_flag         = 1'h0;
    end
    if (pin_src || sync_src.poc_low) begin
      st_next.watchdog_cause_flag    = 1'h0;
      st_next.low_voltage_cause_flag = 1'h0;
    end
    if (watchdog_overflow) begin
      st_next.watchdog_cause_flag = 1'h1;
    end
    if (sync_src.lvd_low) begin
      st_next.low_voltage_cause_flag = 1'h1;
    end

    // Side resets; the detector is spared its own request
    st_next.osc_stop = pin_src;
    st_next.wdt_rst  = int_rst || watchdog_overflow;
    st_next.lvd_rst  = pin_src || sync_src.poc_low || watchdog_overflow;
    st_next.lv_clr   = pin_src || sync_src.poc_low || watchdog_overflow;

    // Release sequence
    case (st_reg.state)
      rsc_pkg::RSC_HOLD: begin
        if (!int_rst) begin
          st_next.state   = rsc_pkg::RSC_OPTION;
          st_next.opt_req = 1'h1;
        end
      end
      rsc_pkg::RSC_OPTION: begin
        if (option_valid) begin
          st_next.opt_req            = 1'h0;
          st_next.xtal               = option_data[rsc_pkg::OPT_XTAL_BIT];
          st_next.reset_pin_as_input = option_data[rsc_pkg::OPT_PIN_IN_BIT];
          st_next.cnt                = rsc_pkg::CNT_RST;
          if (option_data[rsc_pkg::OPT_XTAL_BIT]) begin
            st_next.state = rsc_pkg::RSC_STAB;
          end else begin
            st_next.state = rsc_pkg::RSC_VEC_LO;
          end
        end
      end
      rsc_pkg::RSC_STAB: begin
        st_next.cnt = st_reg.cnt + 16'h0001;
        if (st_reg.cnt == STAB_LAST) begin
          st_next.state = rsc_pkg::RSC_VEC_LO;
        end
      end
      rsc_pkg::RSC_VEC_LO: begin
        // Acknowledgment: defaults land, port pins are handed back
        st_next.state     = rsc_pkg::RSC_VEC_HI;
        st_next.vec_fetch = 1'h1;
        st_next.vec_addr  = rsc_pkg::VEC_ADDR_LO;
        st_next.dflt_load = 1'h1;
        st_next.cpu_reset = 1'h0;
        st_next.pc_undef  = 1'h0;
        st_next.port_hiz  = 1'h0;
      end
      rsc_pkg::RSC_VEC_HI: begin
        st_next.state     = rsc_pkg::RSC_RUN;
        st_next.vec_fetch = 1'h1;
        st_next.vec_addr  = rsc_pkg::VEC_ADDR_HI;
      end
      rsc_pkg::RSC_RUN: begin
        st_next.state = rsc_pkg::RSC_RUN;
      end
      default: begin
        st_next.state = rsc_pkg::RSC_HOLD;
      end
    endcase

    // Any active source overrides the sequence
    if (int_rst) begin
      st_next.state     = rsc_pkg::RSC_HOLD;
      st_next.opt_req   = 1'h0;
      st_next.cpu_reset = 1'h1;
      st_next.pc_undef  = 1'h1;
      st_next.port_hiz  = 1'h1;
      st_next.vec_fetch = 1'h0;
      st_next.dflt_load = 1'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign internal_reset             = int_rst;
  assign option_fetch_req           = st_reg.opt_req;
  assign cpu_reset                  = st_reg.cpu_reset;
  assign pc_undefined               = st_reg.pc_undef;
  assign vector_fetch               = st_reg.vec_fetch;
  assign vector_addr                = st_reg.vec_addr;
  assign defaults_load              = st_reg.dflt_load;
  assign defaults                   = st_reg.dflt;
  assign port_hiz                   = st_reg.port_hiz;
  assign low_driven_port_bit_out    = 1'h0;
  assign low_driven_port_bit_oe     = st_reg.port_hiz;
  assign osc_stop_sys               = st_reg.osc_stop;
  assign osc_stop_lowspeed          = st_reg.osc_stop;
  assign watchdog_unit_reset        = st_reg.wdt_rst;
  assign low_voltage_detector_reset = st_reg.lvd_rst;
  assign low_voltage_regs_clear     = st_reg.lv_clr;
  assign rd_data                    = st_reg.rd_data;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  // Cycles spent in the stabilization wait, for the length check
  logic [15:0] stab_seen;
  always_ff @(posedge clk_sys) begin
    if (srst || st_reg.state != rsc_pkg::RSC_STAB) begin
      stab_seen <= 16'h0000;
    end else begin
      stab_seen <= stab_seen + 16'h0001;
    end
  end

  sequence s_vec_lo;
    vector_fetch && vector_addr == rsc_pkg::VEC_ADDR_LO && defaults_load;
  endsequence

  sequence s_vec_hi;
    vector_fetch && vector_addr == rsc_pkg::VEC_ADDR_HI && !defaults_load;
  endsequence

  sequence s_quiet;
    reset_pin_n && !watchdog_overflow && !power_on_clear_low && !low_voltage_detector_low;
  endsequence

  a_vector_pair: assert property (s_vec_lo |=> s_vec_hi)
    else $error("vector fetch did not follow with high byte");

  a_ports_float: assert property (cpu_reset |-> port_hiz && low_driven_port_bit_oe
                                  && !low_driven_port_bit_out)
    else $error("ports not floating during reset");

  a_release_fetch: assert property ($fell(int_rst) |=> option_fetch_req)
    else $error("option fetch not requested after release");

  a_stab_length: assert property ($rose(vector_fetch) && st_reg.xtal
                                  |-> $past(stab_seen) == STAB_LAST + 16'h0001)
    else $error("stabilization wait has wrong length");

  a_wdt_release: assert property (s_quiet [*3] |-> !int_rst)
    else $error("reset held with no source active");

  a_supply_hold: assert property (sync_src.poc_low || sync_src.lvd_low
                                  |-> int_rst && cpu_reset)
    else $error("reset released while supply low");

  a_osc_stop: assert property (pin_src |=> osc_stop_sys && osc_stop_lowspeed)
    else $error("oscillators not stopped on pin reset");

  a_lvd_spared: assert property (sync_src.lvd_low && !pin_src && !sync_src.poc_low
                                 && !watchdog_overflow |=> !low_voltage_detector_reset
                                 && !low_voltage_regs_clear)
    else $error("detector reset by its own request");

  a_wdt_self: assert property (watchdog_overflow |=> watchdog_unit_reset)
    else $error("watchdog not reset by its overflow");

  a_read_clear: assert property (cause_hit && !watchdog_overflow && !sync_src.lvd_low
                                 |=> !st_reg.watchdog_cause_flag
                                 && !st_reg.low_voltage_cause_flag)
    else $error("cause flags survived a read");

  a_wdt_flag: assert property (watchdog_overflow |=> st_reg.watchdog_cause_flag ##1
                               (rd_data[rsc_pkg::WDT_FLAG_BIT] || !$past(cause_hit)))
    else $error("watchdog cause flag not set");

endmodule : rsc_controller
`default_nettype wire

// [tb/rsc_far_model.sv]
// Far-side model: option byte store answering the controller's fetch request
`default_nettype none
module rsc_far_model (
  // Clock
  input  wire logic       clk_sys,
  // Fetch handshake
  input  wire logic       option_fetch_req,
  output logic            option_valid,
  output logic [7:0]      option_data,
  // Stored byte and answer delay
  input  wire logic [7:0] opt_byte,
  input  wire logic [3:0] delay
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------------
  // Option byte answer
  // ---------------------------------------------------------------------------
  logic [3:0] wait_cnt = 4'h0;

  initial option_valid = 1'b0;

  // One-cycle strobe once the chosen delay has run out
  always @(posedge clk_sys) begin
    if (option_fetch_req && !option_valid && wait_cnt >= delay) begin
      option_valid <= 1'b1;
    end else begin
      option_valid <= 1'b0;
    end
    wait_cnt <= (option_fetch_req && !option_valid) ? wait_cnt + 4'h1 : 4'h0;
  end

  // Data lines show garbage outside the strobe so a stale byte cannot pass
  assign option_data = option_valid ? opt_byte : ~opt_byte;
endmodule : rsc_far_model
`default_nettype wire

// [tb/tb.sv]
// Self-checking testbench of the reset source controller
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------------------
  localparam int            STB  = 8;
  localparam logic [15:0]   CADR = 16'hFF54;

  logic clk_sys = 1'b0, srst = 1'b1, reset_pin_n = 1'b1, watchdog_overflow = 1'b0;
  logic power_on_clear_low = 1'b1, low_voltage_detector_low = 1'b0, rd_en = 1'b0;
  logic option_fetch_req, option_valid, internal_reset, cpu_reset, pc_undefined;
  logic vector_fetch, defaults_load, port_hiz, low_driven_port_bit_out;
  logic low_driven_port_bit_oe, osc_stop_sys, osc_stop_lowspeed, watchdog_unit_reset;
  logic low_voltage_detector_reset, low_voltage_regs_clear;
  logic [15:0] rd_addr = 16'h0000, vector_addr;
  logic [7:0]  option_data, rd_data, opt_byte = 8'h00;
  logic [3:0]  delay = 4'h0;
  rsc_pkg::rsc_defaults_t defaults;
  int errors = 0, total_checks = 0;

  always #25 clk_sys = ~clk_sys;

  rsc_controller #(.STAB_CYCLES(STB)) rsc_controller_inst (.*);
  rsc_far_model rsc_far_model_inst (.clk_sys(clk_sys), .option_fetch_req(option_fetch_req),
    .option_valid(option_valid), .option_data(option_data), .opt_byte(opt_byte),
    .delay(delay));

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // Byte-wide read only; bit reads are not offered
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    rd_en   = 1'b1;
    rd_addr = a;
    @(negedge clk_sys);
    rd_en = 1'b0;
    chk("rd_data", rd_data, exp);
    @(negedge clk_sys);
  endtask : rd

  // Source 0 pin, 1 watchdog, 2 power-on, 3 low voltage
  task automatic hit(input int s, input int n);
    case (s)
      0: reset_pin_n = 1'b0;
      1: watchdog_overflow = 1'b1;
      2: power_on_clear_low = 1'b1;
      default: low_voltage_detector_low = 1'b1;
    endcase
    repeat (n) @(negedge clk_sys);
    chk("osc_stop", {osc_stop_sys, osc_stop_lowspeed}, (s == 0) ? 2'b11 : 2'b00);
    chk("lv_reset", {low_voltage_detector_reset, low_voltage_regs_clear},
        (s == 3) ? 2'b00 : 2'b11);
    chk("wdt_reset", {internal_reset, watchdog_unit_reset}, 2'b11);
    chk("hold", {cpu_reset, port_hiz, low_driven_port_bit_oe, low_driven_port_bit_out,
        pc_undefined}, 5'b11101);
    reset_pin_n              = 1'b1;
    watchdog_overflow        = 1'b0;
    power_on_clear_low       = 1'b0;
    low_voltage_detector_low = 1'b0;
  endtask : hit

  task automatic boot(input logic [7:0] ob, input int stab);
    int n;
    opt_byte = ob;
    n = 0;
    while (option_fetch_req !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    chk("internal_reset", internal_reset, 1'b0);
    n = 0;
    while (option_fetch_req === 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    chk("stab_hold", {port_hiz, pc_undefined}, 2'b11);
    n = 0;
    while (vector_fetch !== 1'b1 && n < STB + 50) begin
      @(negedge clk_sys);
      n++;
    end
    // One extra cycle: the acknowledgment state follows the wait
    chk("stab_len", n, stab + 1);
    chk("vec_lo", {vector_addr, defaults_load, cpu_reset}, {16'h0000, 2'b10});
    chk("defaults", {24'h0, defaults}, {8'h02, 48'h0, 8'h01, 8'h16, 16'hFFFF, 16'h0000});
    @(negedge clk_sys);
    chk("vec_hi", {vector_fetch, vector_addr, defaults_load}, {1'b1, 16'h0001, 1'b0});
    @(negedge clk_sys);
    chk("vec_end", vector_fetch, 1'b0);
  endtask : boot

  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk_sys);
    srst = 1'b0;
    hit(2, 4);
    boot(8'h00, 0);
    rd(CADR, 8'h00);
    hit(1, 4);
    boot(8'h00, 0);
    rd(16'hFF55, 8'h00);
    rd(CADR, 8'h10);
    rd(CADR, 8'h00);
    delay = 4'h5;
    hit(3, 8);
    boot(8'h01, STB);
    hit(1, 4);
    boot(8'h00, 0);
    rd(CADR, 8'h11);
    for (int s = 0; s < 3; s += 2) begin
      hit(1, 4);
      boot(8'h00, 0);
      hit(s, 8);
      boot(8'h00, 0);
      rd(CADR, 8'h00);
    end
    // Pin as input still resets between release and the option read
    delay = 4'h8;
    opt_byte = 8'h02;
    hit(1, 4);
    repeat (4) @(negedge clk_sys);
    reset_pin_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("pin_early", internal_reset, 1'b1);
    reset_pin_n = 1'b1;
    boot(8'h02, 0);
    reset_pin_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("pin_run", {internal_reset, cpu_reset}, 2'b00);
    reset_pin_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    end_of_test();
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
